// *** hw/calm_core.sv ***
//Contract
//- set capacity-low flag when remaining charge falls below low threshold
//- clear capacity-low flag when remaining charge rises above same threshold
//- battery-low pin follows capacity-low flag with no software action
//- voltage below shutdown set threshold sets warning flag and pulses interrupt
//- warning flag clears only when set and voltage above clear level; pulse
//- load mode 0 selects constant current, 1 constant power
//- load model status bit equals the load mode configured one clock earlier
//- current code 0 uses previous discharge cycle average current
//- current code 1 uses present discharge cycle average current
//- current code 2 mean current, code 3 mean current filtered 14 s
//- current code 4 uses design capacity divided by five
//- current code 5 requested rate, code 6 user rate in mA
//- power code 0 uses previous discharge cycle average power
//- power codes 1 present average power, 2 and 3 current times voltage
//- power code 4 design energy over five, code 5 rate times 10 mW
//- power code 6 uses user rate in mW
//- record average discharge current per cycle, keep previous cycle value
module calm_core #(
    parameter int INT_PULSE_CYC = calm_pkg::INT_PULSE_CYC,
    parameter int LPF_TICK_CYC = calm_pkg::LPF_TICK_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // measurements
    input wire logic sample_valid_i,
    input wire logic discharging_i,
    input wire logic [15:0] remaining_charge_value_i,
    input wire logic [15:0] cell_voltage_i,
    input wire logic signed [15:0] mean_current_value_i,
    input wire logic signed [15:0] inst_current_i,
    // configuration
    input wire logic [15:0] low_cap_set_thr_i,
    input wire logic [15:0] shutdown_set_volt_i,
    input wire logic [15:0] shutdown_clear_volt_i,
    input wire logic load_mode_i,
    input wire logic [2:0] load_select_i,
    input wire logic [15:0] design_capacity_i,
    input wire logic [15:0] design_energy_i,
    input wire logic signed [15:0] requested_rate_value_i,
    input wire logic signed [15:0] user_rate_ma_i,
    input wire logic signed [15:0] user_rate_mw_i,
    // status
    output logic capacity_low_flag_o,
    output logic shutdown_warning_flag_o,
    output logic battery_low_output_o,
    output logic charge_state_int_o,
    output logic load_model_status_bit_o,
    output logic signed [31:0] load_value_o,
    output logic signed [15:0] last_avg_current_o,
    output logic signed [15:0] last_avg_power_o
);
    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (INT_PULSE_CYC < 1 || INT_PULSE_CYC > 16777215) begin : g_chk_int
        $error("INT_PULSE_CYC out of range");
    end
    if (LPF_TICK_CYC < 1 || LPF_TICK_CYC > 16777215) begin : g_chk_lpf
        $error("LPF_TICK_CYC out of range");
    end

    localparam logic [23:0] INT_LEN = 24'(INT_PULSE_CYC);
    localparam logic [23:0] TICK_LEN = 24'(LPF_TICK_CYC);

    typedef struct packed {
        logic cap_low;
        logic sd_warn;
        logic int_out;
        logic [23:0] int_cnt;
        logic [23:0] tick_cnt;
        logic signed [31:0] filt;
        logic signed [47:0] sum_i;
        logic signed [47:0] sum_p;
        logic [23:0] n;
        logic dsg;
        logic signed [15:0] last_i;
        logic signed [15:0] last_p;
        logic load_model_status_bit;
        logic signed [31:0] load_val;
    } calm_state_t;

    calm_state_t st;
    calm_state_t next_st;

    logic signed [31:0] inst_pwr;
    logic signed [31:0] mean_pwr;
    logic signed [31:0] filt_pwr;
    logic signed [31:0] pres_i;
    logic signed [31:0] pres_p;
    logic signed [31:0] sel_val;

    // ----------------------------------------
    // derived values
    // ----------------------------------------
    always_comb begin
        inst_pwr = 32'((32'(inst_current_i) * $signed({16'h0000, cell_voltage_i}))
            / calm_pkg::UV_PER_MW);
        mean_pwr = 32'((32'(mean_current_value_i) * $signed({16'h0000, cell_voltage_i}))
            / calm_pkg::UV_PER_MW);
        filt_pwr = 32'((st.filt * $signed({16'h0000, cell_voltage_i})) / calm_pkg::UV_PER_MW);
        if (st.n == 24'h000000) begin
            pres_i = 32'h00000000;
            pres_p = 32'h00000000;
        end else begin
            pres_i = 32'(st.sum_i / $signed({24'h000000, st.n}));
            pres_p = 32'(st.sum_p / $signed({24'h000000, st.n}));
        end
    end

    // ----------------------------------------
    // load model selection
    // ----------------------------------------
    always_comb begin
        sel_val = 32'h00000000;
        if (load_mode_i == calm_pkg::MODE_CC) begin
            case (load_select_i)
                calm_pkg::SEL_PREV: sel_val = 32'(st.last_i);
                calm_pkg::SEL_PRES: sel_val = pres_i;
                calm_pkg::SEL_AVG: sel_val = 32'(mean_current_value_i);
                calm_pkg::SEL_FILT: sel_val = st.filt;
                calm_pkg::SEL_DESIGN: sel_val = 32'(design_capacity_i) / calm_pkg::C_RATE_DIV;
                calm_pkg::SEL_RATE: sel_val = 32'(requested_rate_value_i);
                calm_pkg::SEL_USER: sel_val = 32'(user_rate_ma_i);
                default: sel_val = 32'(st.last_i);
            endcase
        end else begin
            case (load_select_i)
                calm_pkg::SEL_PREV: sel_val = 32'(st.last_p);
                calm_pkg::SEL_PRES: sel_val = pres_p;
                calm_pkg::SEL_AVG: sel_val = mean_pwr;
                calm_pkg::SEL_FILT: sel_val = filt_pwr;
                calm_pkg::SEL_DESIGN: sel_val = 32'(design_energy_i) / calm_pkg::C_RATE_DIV;
                calm_pkg::SEL_RATE: sel_val = 32'(32'(requested_rate_value_i)
                    * calm_pkg::MW_PER_RATE_UNIT);
                calm_pkg::SEL_USER: sel_val = 32'(user_rate_mw_i);
                default: sel_val = 32'(st.last_p);
            endcase
        end
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_st = st;
        next_st.load_model_status_bit = load_mode_i;
        next_st.load_val = sel_val;
        // hysteresis flags, equal value holds
        if (remaining_charge_value_i < low_cap_set_thr_i) begin
            next_st.cap_low = 1'b1;
        end else if (remaining_charge_value_i > low_cap_set_thr_i) begin
            next_st.cap_low = 1'b0;
        end
        if (cell_voltage_i < shutdown_set_volt_i) begin
            next_st.sd_warn = 1'b1;
        end else if (st.sd_warn && cell_voltage_i > shutdown_clear_volt_i) begin
            next_st.sd_warn = 1'b0;
        end
        // interrupt pulse, retriggered by every change of the warning flag
        if (next_st.sd_warn != st.sd_warn) begin
            next_st.int_out = 1'b1;
            next_st.int_cnt = INT_LEN;
        end else if (st.int_cnt > 24'h000001) begin
            next_st.int_cnt = st.int_cnt - 24'h000001;
        end else begin
            next_st.int_out = 1'b0;
            next_st.int_cnt = 24'h000000;
        end
        // first-order filter, one step per second
        if (st.tick_cnt >= TICK_LEN - 24'h000001) begin
            next_st.tick_cnt = 24'h000000;
            next_st.filt = st.filt + (32'(mean_current_value_i) - st.filt) / calm_pkg::LPF_TAU_S;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 24'h000001;
        end
        // discharge cycle averaging
        next_st.dsg = discharging_i;
        if (discharging_i && !st.dsg) begin
            next_st.sum_i = 48'h000000000000;
            next_st.sum_p = 48'h000000000000;
            next_st.n = 24'h000000;
        end else if (discharging_i && sample_valid_i && st.n != 24'hffffff) begin
            next_st.sum_i = st.sum_i + 48'(inst_current_i);
            next_st.sum_p = st.sum_p + 48'(inst_pwr);
            next_st.n = st.n + 24'h000001;
        end
        if (!discharging_i && st.dsg && st.n != 24'h000000) begin
            next_st.last_i = 16'(pres_i);
            next_st.last_p = 16'(pres_p);
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
            st.last_i <= calm_pkg::LAST_I_RST;
            st.last_p <= calm_pkg::LAST_P_RST;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign capacity_low_flag_o = st.cap_low;
    assign battery_low_output_o = st.cap_low;
    assign shutdown_warning_flag_o = st.sd_warn;
    assign charge_state_int_o = st.int_out;
    assign load_model_status_bit_o = st.load_model_status_bit;
    assign load_value_o = st.load_val;
    assign last_avg_current_o = st.last_i;
    assign last_avg_power_o = st.last_p;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_sd_change;
        shutdown_warning_flag_o != $past(shutdown_warning_flag_o);
    endsequence
    sequence s_pulse_held;
        charge_state_int_o [*2];
    endsequence

    property p_cap_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        remaining_charge_value_i < low_cap_set_thr_i |=> capacity_low_flag_o;
    endproperty
    a_cap_set: assert property (p_cap_set) else $error("capacity low not set");

    property p_cap_clr;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        remaining_charge_value_i > low_cap_set_thr_i |=> !capacity_low_flag_o;
    endproperty
    a_cap_clr: assert property (p_cap_clr) else $error("capacity low not cleared");

    property p_pin_follow;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        battery_low_output_o == capacity_low_flag_o;
    endproperty
    a_pin_follow: assert property (p_pin_follow) else $error("battery low pin mismatch");

    property p_sd_set;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cell_voltage_i < shutdown_set_volt_i |=> shutdown_warning_flag_o;
    endproperty
    a_sd_set: assert property (p_sd_set) else $error("shutdown warning not set");

    property p_sd_clr_cause;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $fell(shutdown_warning_flag_o) |-> $past(cell_voltage_i) > $past(shutdown_clear_volt_i);
    endproperty
    a_sd_clr_cause: assert property (p_sd_clr_cause) else $error("warning cleared without cause");

    property p_int_pulse;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        s_sd_change |-> charge_state_int_o;
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("no interrupt on flag change");

    property p_int_width;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(charge_state_int_o) && INT_PULSE_CYC > 1 |-> s_pulse_held;
    endproperty
    a_int_width: assert property (p_int_width) else $error("interrupt pulse too short");

    property p_load_model_status_bit;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        ##1 load_model_status_bit_o == $past(load_mode_i);
    endproperty
    a_load_model_status_bit: assert property (p_load_model_status_bit) else $error("load mode status mismatch");

    property p_sel_rate_cc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CC && load_select_i == calm_pkg::SEL_RATE
        |=> load_value_o == 32'($past(requested_rate_value_i));
    endproperty
    a_sel_rate_cc: assert property (p_sel_rate_cc) else $error("wrong current rate value");

    property p_last_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        discharging_i && $past(discharging_i) |-> $stable(last_avg_current_o);
    endproperty
    a_last_hold: assert property (p_last_hold) else $error("last average changed mid cycle");

    property p_cap_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        remaining_charge_value_i == low_cap_set_thr_i |=> capacity_low_flag_o == $past(capacity_low_flag_o);
    endproperty
    a_cap_hold: assert property (p_cap_hold) else $error("capacity low moved at threshold");

    property p_sd_hold;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        cell_voltage_i >= shutdown_set_volt_i && cell_voltage_i <= shutdown_clear_volt_i
        |=> shutdown_warning_flag_o == $past(shutdown_warning_flag_o);
    endproperty
    a_sd_hold: assert property (p_sd_hold) else $error("warning moved inside hysteresis band");

    property p_int_cause;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(charge_state_int_o) |-> $changed(shutdown_warning_flag_o);
    endproperty
    a_int_cause: assert property (p_int_cause) else $error("interrupt without warning change");

    property p_sel_prev_cc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CC && load_select_i == calm_pkg::SEL_PREV
        |=> load_value_o == 32'($past(last_avg_current_o));
    endproperty
    a_sel_prev_cc: assert property (p_sel_prev_cc) else $error("wrong previous cycle current");

    property p_sel_avg_cc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CC && load_select_i == calm_pkg::SEL_AVG
        |=> load_value_o == 32'($past(mean_current_value_i));
    endproperty
    a_sel_avg_cc: assert property (p_sel_avg_cc) else $error("wrong mean current value");

    property p_sel_design_cc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CC && load_select_i == calm_pkg::SEL_DESIGN
        |=> load_value_o == 32'($past(design_capacity_i)) / calm_pkg::C_RATE_DIV;
    endproperty
    a_sel_design_cc: assert property (p_sel_design_cc) else $error("wrong design capacity rate");

    property p_sel_user_cc;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CC && load_select_i == calm_pkg::SEL_USER
        |=> load_value_o == 32'($past(user_rate_ma_i));
    endproperty
    a_sel_user_cc: assert property (p_sel_user_cc) else $error("wrong user current rate");

    property p_sel_prev_cp;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CP && load_select_i == calm_pkg::SEL_PREV
        |=> load_value_o == 32'($past(last_avg_power_o));
    endproperty
    a_sel_prev_cp: assert property (p_sel_prev_cp) else $error("wrong previous cycle power");

    property p_sel_rate_cp;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CP && load_select_i == calm_pkg::SEL_RATE
        |=> load_value_o == 32'($past(requested_rate_value_i)) * calm_pkg::MW_PER_RATE_UNIT;
    endproperty
    a_sel_rate_cp: assert property (p_sel_rate_cp) else $error("wrong power rate value");

    property p_sel_user_cp;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        load_mode_i == calm_pkg::MODE_CP && load_select_i == calm_pkg::SEL_USER
        |=> load_value_o == 32'($past(user_rate_mw_i));
    endproperty
    a_sel_user_cp: assert property (p_sel_user_cp) else $error("wrong user power rate");
endmodule : calm_core

// *** hw/calm_pkg.sv ***
package calm_pkg;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 100;
    localparam int INT_PULSE_NS = 1000000;
    localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int LPF_TICK_NS = 1000000000;
    localparam int LPF_TICK_CYC = LPF_TICK_NS / CLK_NS;
    localparam int LPF_TAU_S = 14;
    // ----------------------------------------
    // load model codes
    // ----------------------------------------
    localparam logic MODE_CC = 1'h0;
    localparam logic MODE_CP = 1'h1;
    localparam logic [2:0] SEL_PREV = 3'h0;
    localparam logic [2:0] SEL_PRES = 3'h1;
    localparam logic [2:0] SEL_AVG = 3'h2;
    localparam logic [2:0] SEL_FILT = 3'h3;
    localparam logic [2:0] SEL_DESIGN = 3'h4;
    localparam logic [2:0] SEL_RATE = 3'h5;
    localparam logic [2:0] SEL_USER = 3'h6;
    // ----------------------------------------
    // scaling and reset values
    // ----------------------------------------
    localparam int C_RATE_DIV = 5;
    localparam int MW_PER_RATE_UNIT = 10;
    localparam int UV_PER_MW = 1000;
    localparam logic [15:0] LAST_I_RST = 16'hfed4;
    localparam logic [15:0] LAST_P_RST = 16'hfb50;
endpackage : calm_pkg

// *** tb/calm_host_model.sv ***
module calm_host_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    // alert pins
    input wire logic int_i,
    input wire logic cap_low_i,
    input wire logic sd_warn_i,
    // captured flag word and interrupt pulse count
    output logic [1:0] flag_word_o,
    output logic [7:0] pulses_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic int_q;
    // ----------------------------------------
    // flag read on each new interrupt pulse
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            int_q <= 1'h0;
            flag_word_o <= 2'h0;
            pulses_o <= 8'h00;
        end else begin
            int_q <= int_i;
            if (int_i && !int_q) begin
                flag_word_o <= {sd_warn_i, cap_low_i};
                pulses_o <= pulses_o + 8'h01;
            end
        end
    end
endmodule : calm_host_model

// *** tb/charge_alert_load_model_tb.sv ***
module charge_alert_load_model_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst_b, sv, dis, mode, cap_o, sd_o, bl_o, int_o, st_o;
    logic [2:0] sel;
    logic [15:0] rem, volt, thr, sset, sclr, dcap, dene;
    logic signed [15:0] mean, inst, rate, uma, umw, lai_o, lap_o;
    logic signed [31:0] load_o;
    logic [1:0] word;
    logic [7:0] pulses;
    int miscompares = 0, samples_checked = 0, seed = 27;

    calm_core #(.INT_PULSE_CYC(4), .LPF_TICK_CYC(8)) dut (
        .ref_clk_i(ref_clk), .rst_b_i(rst_b), .sample_valid_i(sv), .discharging_i(dis),
        .remaining_charge_value_i(rem), .cell_voltage_i(volt), .mean_current_value_i(mean),
        .inst_current_i(inst), .low_cap_set_thr_i(thr), .shutdown_set_volt_i(sset),
        .shutdown_clear_volt_i(sclr), .load_mode_i(mode), .load_select_i(sel),
        .design_capacity_i(dcap), .design_energy_i(dene), .requested_rate_value_i(rate),
        .user_rate_ma_i(uma), .user_rate_mw_i(umw), .capacity_low_flag_o(cap_o),
        .shutdown_warning_flag_o(sd_o), .battery_low_output_o(bl_o), .charge_state_int_o(int_o),
        .load_model_status_bit_o(st_o), .load_value_o(load_o), .last_avg_current_o(lai_o),
        .last_avg_power_o(lap_o));
    calm_host_model host (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .int_i(int_o), .cap_low_i(cap_o),
        .sd_warn_i(sd_o), .flag_word_o(word), .pulses_o(pulses));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : step
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrap_up
    function automatic logic [31:0] exp_load(input logic m, input logic [2:0] s);
        case (s)
            calm_pkg::SEL_AVG: exp_load = m ? 32'(int'(mean) * int'(volt) / calm_pkg::UV_PER_MW) : 32'(mean);
            calm_pkg::SEL_DESIGN: exp_load = 32'((m ? int'(dene) : int'(dcap)) / calm_pkg::C_RATE_DIV);
            calm_pkg::SEL_RATE: exp_load = m ? 32'(int'(rate) * calm_pkg::MW_PER_RATE_UNIT) : 32'(rate);
            default: exp_load = m ? 32'(umw) : 32'(uma);
        endcase
    endfunction : exp_load

    initial begin
        ref_clk = 1'h0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        wrap_up();
    end
    initial begin
        {rst_b, sv, dis, mode, sel, mean, inst, rate, uma, umw} = '0;
        rem = 16'h0100; thr = 16'h0080; volt = 16'h0e74; sset = 16'h0c80; sclr = 16'h0d48;
        dcap = 16'h03e8; dene = 16'h0e10;
        step(4);
        chk("last_i", 32'hfffffed4, 32'(lai_o));
        chk("last_p", 32'hfffffb50, 32'(lap_o));
        rst_b = 1'h1;
        step(1);
        rem = thr - 16'h0001;
        step(1);
        chk("cap", 32'h1, 32'(cap_o));
        chk("battery_low_output", 32'h1, 32'(bl_o));
        rem = thr;
        step(2);
        chk("cap", 32'h1, 32'(cap_o));
        rem = thr + 16'h0001;
        step(1);
        chk("cap", 32'h0, 32'(cap_o));
        chk("battery_low_output", 32'h0, 32'(bl_o));
        $display("capacity test done");
        volt = sset - 16'h0001;
        step(1);
        chk("sd", 32'h1, 32'(sd_o));
        chk("int", 32'h1, 32'(int_o));
        step(3);
        chk("int", 32'h1, 32'(int_o));
        step(1);
        chk("int", 32'h0, 32'(int_o));
        chk("word", 32'h2, 32'(word));
        volt = sclr;
        step(2);
        chk("sd", 32'h1, 32'(sd_o));
        volt = sclr + 16'h0001;
        step(1);
        chk("sd", 32'h0, 32'(sd_o));
        chk("int", 32'h1, 32'(int_o));
        step(5);
        chk("pulses", 32'h2, 32'(pulses));
        chk("word", 32'h0, 32'(word));
        $display("shutdown test done");
        volt = 16'h0e74; inst = 16'hfe0c;
        step(2);
        chk("load", 32'hfffffed4, load_o);
        mode = 1'h1;
        step(2);
        chk("load", 32'hfffffb50, load_o);
        chk("status", 32'h1, 32'(st_o));
        dis = 1'h1; sel = 3'h1;
        step(1);
        sv = 1'h1;
        step(4);
        sv = 1'h0;
        step(2);
        chk("load", 32'hfffff8c6, load_o);
        mode = 1'h0;
        step(2);
        chk("load", 32'hfffffe0c, load_o);
        dis = 1'h0; sel = 3'h0;
        step(2);
        chk("last_i", 32'hfffffe0c, 32'(lai_o));
        chk("last_p", 32'hfffff8c6, 32'(lap_o));
        chk("load", 32'hfffffe0c, load_o);
        mode = 1'h1;
        step(2);
        chk("load", 32'hfffff8c6, load_o);
        $display("discharge test done");
        for (int i = 0; i < 28; i++) begin
            mode = i[0]; sel = 3'(i % 7);
            mean = 16'($random(seed) % 2000); rate = 16'($random(seed) % 2000);
            uma = 16'($random(seed)); umw = 16'($random(seed)); dcap = 16'($random(seed));
            dene = 16'($random(seed)); volt = 16'(3000 + $random(seed) % 1000);
            step(2);
            chk("status", 32'(mode), 32'(st_o));
            if (sel > 3'h1 && sel != 3'h3) chk("load", exp_load(mode, sel), load_o);
        end
        mode = 1'h0; sel = 3'h3; mean = 16'hfd44;
        step(1200);
        chk("filt_near", 32'h1, 32'((load_o + 32'sd700) < 32'sd14 && (load_o + 32'sd700) > -32'sd14));
        mode = 1'h1; volt = 16'h0e74;
        step(2);
        chk("filt_pwr_near", 32'h1, 32'((load_o + 32'sd2590) < 32'sd60 && (load_o + 32'sd2590) > -32'sd60));
        $display("load select test done");
        wrap_up();
    end
endmodule : charge_alert_load_model_tb
